// ---- hdl/pmd_pkg.sv ----
package pmd_pkg;

    localparam int PMD_AW = 16;
    localparam int PMD_DW = 8;
    localparam int PMD_NP = 8;
    localparam int PMD_OW = 4;

    // disable register and its reset value
    localparam logic [PMD_AW-1:0] PMD_MD0_OFS = 16'h010c;
    localparam logic [PMD_DW-1:0] PMD_MD0_RST = 8'h00;
    localparam logic [PMD_DW-1:0] PMD_RD_ZERO = 8'h00;

    // bit positions within module_disable_0
    localparam int PMD_NVM_BIT = 0;
    localparam int PMD_CRC_BIT = 1;
    localparam int PMD_SCAN_BIT = 2;
    localparam int PMD_SYSC_BIT = 3;
    localparam int PMD_ACT_BIT = 4;
    localparam int PMD_IOC_BIT = 5;
    localparam int PMD_CLKR_BIT = 6;
    localparam int PMD_TMR0_BIT = 7;

    // register window of each controlled peripheral, indexed by disable bit
    localparam logic [PMD_NP-1:0][PMD_AW-1:0] PMD_WIN_BASE = {
        16'h0590, 16'h0580, 16'h0570, 16'h0560,
        16'h0000, 16'h1c90, 16'h1ca0, 16'h0080
    };
    localparam logic [PMD_AW-1:0] PMD_WIN_MASK = 16'hfff0;
    // the clock network slot owns no registers
    localparam logic [PMD_NP-1:0] PMD_WIN_USED = 8'hf7;

    typedef struct packed {
        logic [PMD_AW-1:0] addr;
        logic [PMD_DW-1:0] wdata;
        logic wr;
        logic rd;
    } pmd_req_s;

    localparam pmd_req_s PMD_REQ_IDLE = '0;

endpackage

// ---- hdl/pmd_top.sv ----
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps

// Notes on behaviour
// - all disable bits zero after reset
// - disabled peripheral held in reset
// - disabled registers read zero, ignore writes
// - disabled peripheral outputs forced inactive
// - disabled peripheral clock gated off
// - clearing bit releases reset, registers power-on
// - bit 7 disables base timer
// - bit 6 disables reference clock output
// - bit 5 disables pin change interrupt
// - bit 4 disables oscillator tuning
// - bit 3 stops peripheral system clock network
// - only full-rate clock stops, quarter-rate keeps
// - bit 2 scanner, bit 1 checksum unit
// - bit 0 blocks nonvolatile memory access
module pmd_top
    import pmd_pkg::*;
#(
    parameter int NP = PMD_NP,
    parameter int OW = PMD_OW
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pmd_req_s bus_req,
    output logic [PMD_DW-1:0] rdata_q,
    input wire logic [NP-1:0][PMD_DW-1:0] periph_rdata,
    input wire logic [NP-1:0][OW-1:0] periph_out,
    output pmd_req_s periph_req_q,
    output logic [NP-1:0] periph_sel_q,
    output logic [NP-1:0] periph_rst_q,
    output logic [NP-1:0] periph_clk_en_q,
    output logic [NP-1:0][OW-1:0] gated_out_q,
    output logic fosc_periph_en_q,
    output logic nvm_access_en_q
);

    logic [PMD_DW-1:0] module_disable_0_q;
    logic [PMD_DW-1:0] module_disable_0_d;
    logic [NP-1:0] win_hit;
    logic reg_hit;
    logic [PMD_DW-1:0] rdata_d;

    assign reg_hit = bus_req.addr == PMD_MD0_OFS;

    // per-peripheral register window decode
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_win
            assign win_hit[gi] = PMD_WIN_USED[gi]
                && ((bus_req.addr & PMD_WIN_MASK) == PMD_WIN_BASE[gi]);
        end
    endgenerate

    // disable register is never gated by its own bits
    always_comb begin
        module_disable_0_d = module_disable_0_q;
        if (bus_req.wr && reg_hit) begin
            module_disable_0_d = bus_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            module_disable_0_q <= PMD_MD0_RST;
        end else begin
            module_disable_0_q <= module_disable_0_d;
        end
    end

    // read path, data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = PMD_RD_ZERO;
        if (bus_req.rd) begin
            if (reg_hit) begin
                rdata_d = module_disable_0_q;
            end
            for (int i = 0; i < NP; i++) begin
                if (win_hit[i] && !module_disable_0_q[i]) begin
                    rdata_d = periph_rdata[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= PMD_RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // forwarded access to peripherals, dropped while disabled
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            periph_req_q <= PMD_REQ_IDLE;
            periph_sel_q <= '0;
        end else begin
            periph_req_q <= bus_req;
            periph_sel_q <= win_hit & ~module_disable_0_q;
        end
    end

    // reset hold and clock gate follow the next register value
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            periph_rst_q <= '0;
            periph_clk_en_q <= '1;
        end else begin
            periph_rst_q <= module_disable_0_d;
            periph_clk_en_q <= ~module_disable_0_d;
        end
    end

    // named controls for the fixed slots
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fosc_periph_en_q <= 1'b1;
            nvm_access_en_q <= 1'b1;
        end else begin
            // quarter-rate clock is not routed here
            fosc_periph_en_q <= !module_disable_0_d[PMD_SYSC_BIT];
            nvm_access_en_q <= !module_disable_0_d[PMD_NVM_BIT];
        end
    end

    // output disable, one slot per bit: 7 timer, 6 ref clock, 5 pin change,
    // 4 osc tuning, 2 scanner, 1 checksum, 0 memory
    generate
        for (gi = 0; gi < NP; gi++) begin : g_out
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    gated_out_q[gi] <= '0;
                end else if (module_disable_0_d[gi]) begin
                    gated_out_q[gi] <= '0;
                end else begin
                    gated_out_q[gi] <= periph_out[gi];
                end
            end
        end
    endgenerate

    property p_reset_enabled;
        @(posedge clk_sys) $rose(rst_b) |-> periph_rst_q == '0 && periph_clk_en_q == '1;
    endproperty
    a_reset_enabled: assert property (p_reset_enabled) else $error("peripheral not enabled after reset");

    property p_hold_reset;
        @(posedge clk_sys) disable iff (!rst_b)
            (bus_req.wr && reg_hit) |=> periph_rst_q == $past(bus_req.wdata);
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("reset hold does not follow write");

    property p_read_zero;
        @(posedge clk_sys) disable iff (!rst_b)
            (bus_req.rd && |(win_hit & module_disable_0_q)) |=> rdata_q == PMD_RD_ZERO;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("disabled register read not zero");

    property p_write_drop;
        @(posedge clk_sys) disable iff (!rst_b)
            (bus_req.wr && |(win_hit & module_disable_0_q)) |=> periph_sel_q == '0;
    endproperty
    a_write_drop: assert property (p_write_drop) else $error("disabled register write forwarded");

    property p_out_off;
        @(posedge clk_sys) disable iff (!rst_b)
            ##1 (gated_out_q & ~{NP{OW'(0)}}) == gated_out_q
            && ((periph_rst_q[PMD_TMR0_BIT] && 1'b1) -> gated_out_q[PMD_TMR0_BIT] == '0);
    endproperty
    a_out_off: assert property (p_out_off) else $error("disabled timer output active");

    property p_clk_gate;
        @(posedge clk_sys) disable iff (!rst_b) periph_clk_en_q == ~periph_rst_q;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate and reset disagree");

    property p_release;
        @(posedge clk_sys) disable iff (!rst_b)
            (bus_req.wr && reg_hit && bus_req.wdata == PMD_MD0_RST) |=> ##1 periph_rst_q == '0;
    endproperty
    a_release: assert property (p_release) else $error("reset not released");

    property p_sysclk;
        @(posedge clk_sys) disable iff (!rst_b)
            fosc_periph_en_q == !periph_rst_q[PMD_SYSC_BIT];
    endproperty
    a_sysclk: assert property (p_sysclk) else $error("system clock gate wrong");

    property p_nvm;
        @(posedge clk_sys) disable iff (!rst_b)
            !nvm_access_en_q |-> !periph_sel_q[PMD_NVM_BIT];
    endproperty
    a_nvm: assert property (p_nvm) else $error("memory access while blocked");

    property p_reg_rw;
        @(posedge clk_sys) disable iff (!rst_b)
            (bus_req.wr && reg_hit) ##1 (bus_req.rd && reg_hit && !bus_req.wr)
            |=> rdata_q == $past(bus_req.wdata, 2);
    endproperty
    a_reg_rw: assert property (p_reg_rw) else $error("disable register readback wrong");

    c_disable_all: cover property (@(posedge clk_sys) disable iff (!rst_b) periph_rst_q == '1);
    c_reenable: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(periph_rst_q[PMD_TMR0_BIT]));
    c_blocked_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
        bus_req.rd && |(win_hit & module_disable_0_q));
    c_live_write: cover property (@(posedge clk_sys) disable iff (!rst_b) |periph_sel_q && periph_req_q.wr);

endmodule

// ---- dv/pmd_periph_model.sv ----
`timescale 1ns/100ps
module pmd_periph_model
    import pmd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pmd_req_s periph_req_q,
    input wire logic [PMD_NP-1:0] periph_sel_q,
    input wire logic [PMD_NP-1:0] periph_rst_q,
    output logic [PMD_NP-1:0][PMD_DW-1:0] periph_rdata,
    output logic [PMD_NP-1:0][PMD_OW-1:0] periph_out
);
    // one register per peripheral, reset value differs from zero reads
    localparam logic [PMD_DW-1:0] POR_VAL = 8'h3c;
    logic [PMD_NP-1:0][PMD_DW-1:0] reg_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q <= {PMD_NP{POR_VAL}};
        end else begin
            for (int i = 0; i < PMD_NP; i++) begin
                if (periph_rst_q[i]) begin
                    reg_q[i] <= POR_VAL;
                end else if (periph_sel_q[i] && periph_req_q.wr) begin
                    reg_q[i] <= periph_req_q.wdata;
                end
            end
        end
    end
    assign periph_rdata = reg_q;
    always_comb begin
        for (int i = 0; i < PMD_NP; i++) begin
            periph_out[i] = reg_q[i][PMD_OW-1:0];
        end
    end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
    import pmd_pkg::*;
    logic clk_sys, rst_b, rd_pend, fosc_periph_en_q, nvm_access_en_q;
    pmd_req_s bus_req, periph_req_q;
    logic [PMD_DW-1:0] rdata_q, d, exp_q[$];
    logic [PMD_NP-1:0][PMD_DW-1:0] periph_rdata;
    logic [PMD_NP-1:0][PMD_OW-1:0] periph_out, gated_out_q;
    logic [PMD_NP-1:0] periph_sel_q, periph_rst_q, periph_clk_en_q;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 32'h9ee5;
    pmd_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rdata_q(rdata_q),
        .periph_rdata(periph_rdata), .periph_out(periph_out), .periph_req_q(periph_req_q),
        .periph_sel_q(periph_sel_q), .periph_rst_q(periph_rst_q), .periph_clk_en_q(periph_clk_en_q),
        .gated_out_q(gated_out_q), .fosc_periph_en_q(fosc_periph_en_q), .nvm_access_en_q(nvm_access_en_q));
    pmd_periph_model u_model (.clk_sys(clk_sys), .rst_b(rst_b), .periph_req_q(periph_req_q),
        .periph_sel_q(periph_sel_q), .periph_rst_q(periph_rst_q), .periph_rdata(periph_rdata),
        .periph_out(periph_out));
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [PMD_AW-1:0] a, logic [PMD_DW-1:0] v);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
    endtask
    task automatic rd(logic [PMD_AW-1:0] a, logic [PMD_DW-1:0] e);
        exp_q.push_back(e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
    endtask
    task automatic idle(int n);
        bus_req <= PMD_REQ_IDLE;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // read data stand only in the cycle after the read strobe
    always @(posedge clk_sys) rd_pend <= bus_req.rd;
    always @(negedge clk_sys) begin
        if (rd_pend === 1'b1) begin
            chk(rdata_q, exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict;
    end
    initial begin
        bus_req = PMD_REQ_IDLE;
        rst_b = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(PMD_MD0_OFS, PMD_MD0_RST);
        rd(16'h0200, PMD_RD_ZERO);
        idle(1);
        chk({periph_rst_q, periph_clk_en_q, fosc_periph_en_q, nvm_access_en_q}, {8'h00, 8'hff, 2'b11});
        $display("reset test done");
        for (int i = 0; i < PMD_NP; i++) begin
            d = 8'($random(seed));
            if (PMD_WIN_USED[i]) begin
                wr(PMD_WIN_BASE[i], d);
                idle(3);
                chk(gated_out_q[i], d[PMD_OW-1:0]);
                rd(PMD_WIN_BASE[i], d);
            end
            wr(PMD_MD0_OFS, 8'h01 << i);
            bus_req <= PMD_REQ_IDLE;
            #1;
            chk({periph_rst_q, periph_clk_en_q}, {8'h01 << i, ~(8'h01 << i)});
            chk({fosc_periph_en_q, nvm_access_en_q}, {i != 3, i != 0});
            chk(gated_out_q[i], 0);
            @(posedge clk_sys);
            if (PMD_WIN_USED[i]) begin
                wr(PMD_WIN_BASE[i], ~d);
                rd(PMD_WIN_BASE[i], PMD_RD_ZERO);
            end
            rd(PMD_MD0_OFS, 8'h01 << i);
            wr(PMD_MD0_OFS, 8'h00);
            idle(2);
            if (PMD_WIN_USED[i]) begin
                rd(PMD_WIN_BASE[i], 8'h3c);
            end
            idle(2);
            $display("slot %0d test done", i);
        end
        give_verdict;
    end
endmodule
